// ===== hw/closed_loop_config_regs.sv
// Purpose: Closed-loop configuration registers with speed-pulse output
// Assumes: Motor-side inputs come from logic on the same clock
// Notes: AXI4-Lite slave, one write and one read in flight at a time
// Summary of operation
// (R1) Bit 14 picks continuous (0) or discontinuous (1) SVM; resets to 0.
// (R2) Bits 13-12 run the pulse in both, closed or first open try; 3h invalid.
// (R3) Bits 11-8 divide the pulse rate by the field; 0 and 1 mean one.
// (R4) Bit 7: pulse while driven (0) or until back-EMF drops below limit (1).
// (R5) Bits 6-4 set back-EMF limit: 1, 2, 5, 10, 20, 30 mV; 6h, 7h invalid.
// (R6) Bit 3 turns on voltage-surge prevention and resets off.
// (R7) Bit 2 turns on dead-time compensation and resets off.
// (R8) Bit 1 turns the speed loop off when set; reset leaves the loop on.
// (R9) Bit 0: Hi-Z (0) or low brake (1) on recirc stop in align/open loop.
// (R10) The second word sits at index 8Ah and reads all zero after reset.
// (R11) Word two bits 30-28: Hi-Z, recirc, low, high, spin-down, align brake.
// (R12) Word two: parity, stop fields, two speed limits, resistance, inductance.
`timescale 1ns/10ps
module closed_loop_config_regs #(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic motor_driven,
  input wire logic loop_closed,
  input wire logic first_attempt,
  input wire logic elec_pulse,
  input wire logic [7:0] back_emf_mv,
  input wire logic stop_request,
  input wire logic in_align_or_open,
  output logic speed_pulse_output,
  output logic [2:0] stage_cmd,
  output logic discontinuous_svm,
  output logic surge_prevention_on,
  output logic deadtime_comp_on,
  output logic velocity_loop_off,
  output logic [2:0] halt_method,
  output logic [3:0] halt_brake_duration,
  output logic [3:0] spin_down_threshold,
  output logic [3:0] brake_speed_threshold,
  output logic [7:0] winding_resistance,
  output logic [7:0] winding_inductance
);
  if (ADDR_W < clreg_pkg::MIN_ADDR_W) begin : g_chk
    $error("ADDR_W too small for the register map");
  end

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  typedef struct packed {
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [14:0] cfg_a;
    logic [31:0] cfg_b;
    logic coast_active;
  } regs_state_t;

  localparam regs_state_t RESET_ST = '{
    aw_held: 1'b0, w_held: 1'b0, waddr: '0, wdata: 32'h0000_0000,
    wstrb: 4'h0, awready: 1'b0, wready: 1'b0, bvalid: 1'b0,
    bresp: clreg_pkg::RESP_OKAY, arready: 1'b0, rvalid: 1'b0,
    rdata: 32'h0000_0000, rresp: clreg_pkg::RESP_OKAY,
    cfg_a: clreg_pkg::CFG_A_RESET, cfg_b: clreg_pkg::CFG_B_RESET,
    coast_active: 1'b0};

  regs_state_t st;
  regs_state_t next_st;
  logic wr_fire;
  logic [1:0] wsel;
  logic [1:0] rsel;
  logic src_ok;
  logic pulse_gate;
  logic [1:0] source;
  logic activity;
  logic [7:0] thr;

  // Shared by the read and the write path
  function automatic logic [1:0] reg_select(input logic [ADDR_W-1:0] addr);
    if (addr == ADDR_W'({clreg_pkg::IDX_CFG_A, 2'b00})) begin
      reg_select = clreg_pkg::SEL_A;
    end else if (addr == ADDR_W'({clreg_pkg::IDX_CFG_B, 2'b00})) begin
      reg_select = clreg_pkg::SEL_B; // (R10)
    end else begin
      reg_select = clreg_pkg::SEL_NONE;
    end
  endfunction

  function automatic logic [31:0] merge_lanes(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
    merge_lanes = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge_lanes[8*i +: 8] = data[8*i +: 8];
      end
    end
  endfunction

  assign source = st.cfg_a[clreg_pkg::SRC_LSB +: 2];
  assign activity = st.cfg_a[clreg_pkg::ACT_BIT];
  assign thr = clreg_pkg::thr_mv(st.cfg_a[clreg_pkg::THR_LSB +: 3]); // (R5)

  always_comb begin
    logic [31:0] merged;
    merged = 32'h0000_0000;
    next_st = st;
    wsel = reg_select(st.waddr);
    rsel = reg_select(s_axi_araddr);
    wr_fire = st.aw_held && st.w_held && !st.bvalid;

    if (s_axi_awvalid && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = clreg_pkg::RESP_OKAY;
      if (wsel == clreg_pkg::SEL_A) begin
        merged = merge_lanes({17'h0_0000, st.cfg_a}, st.wdata, st.wstrb);
        next_st.cfg_a = merged[14:0]; // (R1)
      end else if (wsel == clreg_pkg::SEL_B) begin
        next_st.cfg_b = merge_lanes(st.cfg_b, st.wdata, st.wstrb); // (R12)
      end else begin
        next_st.bresp = clreg_pkg::RESP_SLVERR;
      end
    end
    // Ready only while the slot is free, so one write at a time
    next_st.awready = !next_st.aw_held && !next_st.bvalid;
    next_st.wready = !next_st.w_held && !next_st.bvalid;

    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = clreg_pkg::RESP_OKAY;
      if (rsel == clreg_pkg::SEL_A) begin
        // Upper bits of the first word are not held here
        next_st.rdata = {17'h0_0000, st.cfg_a};
      end else if (rsel == clreg_pkg::SEL_B) begin
        next_st.rdata = st.cfg_b; // (R10)
      end else begin
        next_st.rdata = 32'h0000_0000;
        next_st.rresp = clreg_pkg::RESP_SLVERR;
      end
    end
    next_st.arready = !next_st.rvalid;

    // Coasting window for the speed pulse after drive stops
    if (motor_driven) begin
      next_st.coast_active = 1'b1;
    end else if (back_emf_mv < thr) begin
      next_st.coast_active = 1'b0; // (R5)
    end
  end

  always_comb begin
    unique case (source) // (R2)
      clreg_pkg::SRC_BOTH: src_ok = 1'b1;
      clreg_pkg::SRC_CLOSED: src_ok = loop_closed;
      clreg_pkg::SRC_FIRST_OPEN: src_ok = !loop_closed && first_attempt;
      default: src_ok = 1'b0;
    endcase
    pulse_gate = src_ok
                 && (motor_driven || (activity && st.coast_active)); // (R4)
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= RESET_ST;
    end else begin
      st <= next_st;
    end
  end

  pulse_divider #(
    .DIV_W(4)
  ) u_div (
    .clk(clk),
    .rst_n(rst_n),
    .enable(pulse_gate),
    .pulse_in(elec_pulse),
    .divide(st.cfg_a[clreg_pkg::DIV_LSB +: 4]), // (R3)
    .pulse_out(speed_pulse_output)
  );

  halt_stage u_halt (
    .clk(clk),
    .rst_n(rst_n),
    .stop_request(stop_request),
    .in_align_or_open(in_align_or_open),
    .slow_stop_choice(st.cfg_a[clreg_pkg::SLOW_BIT]), // (R9)
    .halt_method(st.cfg_b[clreg_pkg::HALT_LSB +: 3]), // (R11)
    .stage_cmd(stage_cmd)
  );

  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign discontinuous_svm = st.cfg_a[clreg_pkg::MODE_BIT]; // (R1)
  assign surge_prevention_on = st.cfg_a[clreg_pkg::SURGE_BIT]; // (R6)
  assign deadtime_comp_on = st.cfg_a[clreg_pkg::DT_BIT]; // (R7)
  assign velocity_loop_off = st.cfg_a[clreg_pkg::LOOPOFF_BIT]; // (R8)
  assign halt_method = st.cfg_b[clreg_pkg::HALT_LSB +: 3];
  assign halt_brake_duration = st.cfg_b[clreg_pkg::BRK_LSB +: 4]; // (R12)
  assign spin_down_threshold = st.cfg_b[clreg_pkg::SPIN_LSB +: 4];
  assign brake_speed_threshold = st.cfg_b[clreg_pkg::BRKSPD_LSB +: 4];
  assign winding_resistance = st.cfg_b[clreg_pkg::RES_LSB +: 8];
  assign winding_inductance = st.cfg_b[clreg_pkg::IND_LSB +: 8];

  sequence s_write_a_hi;
    wr_fire && wsel == clreg_pkg::SEL_A && st.wstrb[1];
  endsequence
  sequence s_write_b_lane1;
    wr_fire && wsel == clreg_pkg::SEL_B && st.wstrb[1];
  endsequence

  a_mode_write: assert property ( // (R1)
    s_write_a_hi |=> discontinuous_svm == $past(st.wdata[14]))
    else $error("modulation select not updated");
  a_invalid_source: assert property ( // (R2)
    source == clreg_pkg::SRC_ILLEGAL |=> !speed_pulse_output)
    else $error("speed pulse ran with invalid source");
  a_closed_only: assert property ( // (R2)
    source == clreg_pkg::SRC_CLOSED && !loop_closed |=> !speed_pulse_output)
    else $error("speed pulse ran in open loop");
  a_first_open: assert property ( // (R2)
    source == clreg_pkg::SRC_FIRST_OPEN && (loop_closed || !first_attempt)
    |=> !speed_pulse_output)
    else $error("speed pulse ran past the first open try");
  a_drive_window: assert property ( // (R4)
    !activity && !motor_driven |=> !speed_pulse_output)
    else $error("speed pulse ran without drive");
  a_coast_end: assert property ( // (R5)
    !motor_driven && back_emf_mv < thr |=> !st.coast_active ##1
    (!speed_pulse_output || $past(motor_driven)))
    else $error("coast window outlived back-EMF");
  a_surge_reset: assert property ( // (R6)
    !$past(rst_n) |-> !surge_prevention_on)
    else $error("surge prevention on after reset");
  a_deadtime_reset: assert property ( // (R7)
    !$past(rst_n) |-> !deadtime_comp_on)
    else $error("dead-time compensation on after reset");
  a_loop_reset: assert property ( // (R8)
    !$past(rst_n) |-> !velocity_loop_off)
    else $error("speed loop off after reset");
  a_word_b_reset: assert property ( // (R10)
    !$past(rst_n) |-> st.cfg_b == clreg_pkg::CFG_B_RESET)
    else $error("second word not zero after reset");
  a_read_b_data: assert property ( // (R10)
    s_axi_arvalid && st.arready && rsel == clreg_pkg::SEL_B
    |=> s_axi_rvalid && s_axi_rdata == $past(st.cfg_b))
    else $error("second word read mismatch");
  a_unmapped_write: assert property ( // (R10)
    wr_fire && wsel == clreg_pkg::SEL_NONE |=> $stable(st.cfg_b))
    else $error("unmapped write changed the second word");
  a_resistance_write: assert property ( // (R12)
    s_write_b_lane1 |=> winding_resistance == $past(st.wdata[15:8]))
    else $error("winding resistance not updated");
endmodule

// ===== shared/clreg_pkg.sv
// Purpose: Constants for the closed-loop configuration register bank
// Assumes: 32-bit AXI4-Lite data, word-indexed register map
// Notes: Byte address of a register is four times its index
package clreg_pkg;
  // Register indices; byte address = index * 4
  localparam logic [7:0] IDX_CFG_A = 8'h89;
  localparam logic [7:0] IDX_CFG_B = 8'h8A;
  localparam int unsigned MIN_ADDR_W = 10;

  // Decoded register select
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_A = 2'h1;
  localparam logic [1:0] SEL_B = 2'h2;

  // First word field positions
  localparam int unsigned CFG_A_W = 15;
  localparam int unsigned MODE_BIT = 14;
  localparam int unsigned SRC_LSB = 12;
  localparam int unsigned DIV_LSB = 8;
  localparam int unsigned ACT_BIT = 7;
  localparam int unsigned THR_LSB = 4;
  localparam int unsigned SURGE_BIT = 3;
  localparam int unsigned DT_BIT = 2;
  localparam int unsigned LOOPOFF_BIT = 1;
  localparam int unsigned SLOW_BIT = 0;
  localparam logic [14:0] CFG_A_RESET = 15'h0000;

  // Second word field positions
  localparam int unsigned PARITY_BIT = 31;
  localparam int unsigned HALT_LSB = 28;
  localparam int unsigned BRK_LSB = 24;
  localparam int unsigned SPIN_LSB = 20;
  localparam int unsigned BRKSPD_LSB = 16;
  localparam int unsigned RES_LSB = 8;
  localparam int unsigned IND_LSB = 0;
  localparam logic [31:0] CFG_B_RESET = 32'h0000_0000;

  // Speed-pulse source codes; 3h is illegal
  localparam logic [1:0] SRC_BOTH = 2'h0;
  localparam logic [1:0] SRC_CLOSED = 2'h1;
  localparam logic [1:0] SRC_FIRST_OPEN = 2'h2;
  localparam logic [1:0] SRC_ILLEGAL = 2'h3;

  // Halt method codes
  localparam logic [2:0] HALT_HIZ = 3'h0;
  localparam logic [2:0] HALT_RECIRC = 3'h1;
  localparam logic [2:0] HALT_LOW = 3'h2;
  localparam logic [2:0] HALT_HIGH = 3'h3;
  localparam logic [2:0] HALT_SPIN = 3'h4;
  localparam logic [2:0] HALT_ALIGN = 3'h5;

  // Output stage command codes
  localparam logic [2:0] STAGE_DRIVE = 3'h0;
  localparam logic [2:0] STAGE_HIZ = 3'h1;
  localparam logic [2:0] STAGE_RECIRC = 3'h2;
  localparam logic [2:0] STAGE_LOW = 3'h3;
  localparam logic [2:0] STAGE_HIGH = 3'h4;
  localparam logic [2:0] STAGE_SPIN = 3'h5;
  localparam logic [2:0] STAGE_ALIGN = 3'h6;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Back-EMF threshold in mV; illegal codes behave as the top entry
  function automatic logic [7:0] thr_mv(input logic [2:0] code);
    unique case (code)
      3'h0: thr_mv = 8'h01;
      3'h1: thr_mv = 8'h02;
      3'h2: thr_mv = 8'h05;
      3'h3: thr_mv = 8'h0A;
      3'h4: thr_mv = 8'h14;
      default: thr_mv = 8'h1E;
    endcase
  endfunction
endpackage

// ===== hw/pulse_divider.sv
// Purpose: Divide the electrical pulse train for the speed-pulse pin
// Assumes: pulse_in is a one-cycle strobe on clk
// Notes: Output toggles once per divide pulses; low while disabled
`timescale 1ns/10ps
module pulse_divider #(
  parameter int DIV_W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic pulse_in,
  input wire logic [DIV_W-1:0] divide,
  output logic pulse_out
);
  if (DIV_W < 2) begin : g_chk
    $error("pulse_divider needs DIV_W of at least 2");
  end

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic level;
  } div_state_t;

  div_state_t st;
  div_state_t next_st;
  logic [DIV_W-1:0] eff;

  always_comb begin
    // Codes 0 and 1 both divide by one
    eff = (divide <= DIV_W'(1)) ? DIV_W'(1) : divide; // (R3)
    next_st = st;
    if (!enable) begin
      next_st.cnt = '0;
      next_st.level = 1'b0;
    end else if (pulse_in) begin
      if (st.cnt >= eff - DIV_W'(1)) begin
        next_st.cnt = '0;
        next_st.level = ~st.level;
      end else begin
        next_st.cnt = st.cnt + DIV_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pulse_out = st.level;

  // A lowered divide may leave the count above it for one wrap
  a_div_count_range: assert property ( // (R3)
    $stable(divide) && $past(st.cnt) < $past(eff) |-> st.cnt < eff)
    else $error("divider count out of range");
  a_div_by_one: assert property ( // (R3)
    enable && pulse_in && divide <= DIV_W'(1)
    |=> pulse_out != $past(pulse_out))
    else $error("divide by one missed a toggle");
endmodule

// ===== hw/halt_stage.sv
// Purpose: Pick the output stage command for a motor stop request
// Assumes: Inputs come from logic on the same clock
// Notes: Illegal halt codes fall back to high impedance, the safe state
`timescale 1ns/10ps
module halt_stage (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic stop_request,
  input wire logic in_align_or_open,
  input wire logic slow_stop_choice,
  input wire logic [2:0] halt_method,
  output logic [2:0] stage_cmd
);
  typedef struct packed {
    logic [2:0] cmd;
  } halt_state_t;

  halt_state_t st;
  halt_state_t next_st;

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  always_comb begin
    next_st = st;
    if (!stop_request) begin
      next_st.cmd = clreg_pkg::STAGE_DRIVE;
    end else begin
      unique case (halt_method) // (R11)
        clreg_pkg::HALT_HIZ: next_st.cmd = clreg_pkg::STAGE_HIZ;
        clreg_pkg::HALT_RECIRC: begin
          // Recirculation is unsafe before closed loop
          if (in_align_or_open) begin
            next_st.cmd = slow_stop_choice ? clreg_pkg::STAGE_LOW
                                           : clreg_pkg::STAGE_HIZ; // (R9)
          end else begin
            next_st.cmd = clreg_pkg::STAGE_RECIRC;
          end
        end
        clreg_pkg::HALT_LOW: next_st.cmd = clreg_pkg::STAGE_LOW;
        clreg_pkg::HALT_HIGH: next_st.cmd = clreg_pkg::STAGE_HIGH;
        clreg_pkg::HALT_SPIN: next_st.cmd = clreg_pkg::STAGE_SPIN;
        clreg_pkg::HALT_ALIGN: next_st.cmd = clreg_pkg::STAGE_ALIGN;
        default: next_st.cmd = clreg_pkg::STAGE_HIZ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign stage_cmd = st.cmd;

  a_recirc_slow: assert property ( // (R9)
    stop_request && halt_method == clreg_pkg::HALT_RECIRC && in_align_or_open
    |=> stage_cmd == ($past(slow_stop_choice) ? clreg_pkg::STAGE_LOW
                                              : clreg_pkg::STAGE_HIZ))
    else $error("slow stop choice not applied");
  a_method_map: assert property ( // (R11)
    stop_request && halt_method == clreg_pkg::HALT_LOW
    |=> stage_cmd == clreg_pkg::STAGE_LOW)
    else $error("low-side braking not selected");
endmodule

// ===== tb/speed_pulse_monitor.sv
// Purpose: System controller side that tallies speed-pulse edges
// Assumes: Pin sampled on the block clock, already clean
// Notes: Counts both edges; clear restarts the tally
`timescale 1ns/10ps
module speed_pulse_monitor (
  input wire logic clk,
  input wire logic clear,
  input wire logic pulse_pin,
  output logic [15:0] edges
);
  logic last;
  initial begin
    last = 1'b0;
    edges = 16'h0000;
  end
  // Plain sampler: a real controller sees nothing finer than one cycle
  always @(posedge clk) begin
    last <= pulse_pin;
    if (clear) begin
      edges <= 16'h0000;
    end else if (pulse_pin !== last) begin
      edges <= edges + 16'h0001;
    end
  end
endmodule

// ===== tb/closed_loop_config_regs_bench.sv
// Purpose: Self-checking bench for the closed-loop config registers
// Assumes: AXI4-Lite master tasks; speed pulse tallied by a monitor
// Notes: Registered outputs are checked two edges after their cause
`timescale 1ns/10ps
module closed_loop_config_regs_bench;
  localparam logic [11:0] AD_A = {2'b00, clreg_pkg::IDX_CFG_A, 2'b00};
  localparam logic [11:0] AD_B = {2'b00, clreg_pkg::IDX_CFG_B, 2'b00};
  localparam logic [1:0] OK = clreg_pkg::RESP_OKAY;
  localparam int BP[4] = '{14, 3, 2, 1};
  localparam int DV[5] = '{0, 1, 2, 3, 15};
  localparam logic [4:0] ST[8] = '{5'h01, 5'h05, 5'h0A, 5'h0D,
                                    5'h13, 5'h16, 5'h10, 5'h1E};
  localparam logic [2:0] STG[8] = '{3'h1, 3'h2, 3'h3, 3'h4,
                                     3'h5, 3'h6, 3'h1, 3'h1};
  localparam logic [7:0] MV[8] = '{8'h01, 8'h02, 8'h05, 8'h0A,
                                    8'h14, 8'h1E, 8'h1E, 8'h1E};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic driven = 1'b0, lclosed = 1'b0, first = 1'b0, epulse = 1'b0;
  logic stop = 1'b0, align = 1'b0, clr = 1'b0;
  logic [7:0] emf = 8'h00;
  logic spo, svm, surge, dtc, loopoff;
  logic [2:0] stage, halt;
  logic [3:0] brk, spin, bspd;
  logic [7:0] res, ind;
  logic [15:0] edges;
  int miscompares = 0;
  int n_checks = 0;

  always #25 clk = ~clk;

  closed_loop_config_regs #(.ADDR_W(12)) u_dut (
    .clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .motor_driven(driven), .loop_closed(lclosed),
    .first_attempt(first), .elec_pulse(epulse), .back_emf_mv(emf),
    .stop_request(stop), .in_align_or_open(align),
    .speed_pulse_output(spo), .stage_cmd(stage),
    .discontinuous_svm(svm), .surge_prevention_on(surge),
    .deadtime_comp_on(dtc), .velocity_loop_off(loopoff),
    .halt_method(halt), .halt_brake_duration(brk),
    .spin_down_threshold(spin), .brake_speed_threshold(bspd),
    .winding_resistance(res), .winding_inductance(ind)
  );

  speed_pulse_monitor u_mon (
    .clk(clk), .clear(clr), .pulse_pin(spo), .edges(edges)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 40);
    chk({31'h0, bvalid}, 32'h1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 40);
    chk({31'h0, rvalid}, 32'h1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, 4'hF, r);
    chk({30'h0, r}, {30'h0, OK});
  endtask

  task automatic rreg(input logic [11:0] a, input logic [31:0] e,
                      input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic pulses(input int k, input int exp);
    repeat (k) begin
      @(posedge clk);
      epulse <= 1'b1;
      @(posedge clk);
      epulse <= 1'b0;
    end
    repeat (3) @(posedge clk);
    chk({16'h0, edges}, 32'(exp));
  endtask

  // Gate off long enough to zero the divider, then restart the tally
  task automatic restart(input logic lc, input logic fa);
    @(posedge clk);
    driven <= 1'b0;
    repeat (2) @(posedge clk);
    clr <= 1'b1;
    lclosed <= lc;
    first <= fa;
    @(posedge clk);
    clr <= 1'b0;
    driven <= 1'b1;
  endtask

  task automatic coast(input logic [2:0] c, input logic [7:0] mv);
    wreg(AD_A, 32'h0000_0080 | (32'(c) << 4));
    restart(1'b0, 1'b0);
    @(posedge clk);
    emf <= mv;
    driven <= 1'b0;
    pulses(2, 2);
    emf <= mv - 8'h01;
    pulses(2, 2);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Whole run is under a thousand cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    conclude();
  end

  initial begin
    logic [1:0] r;
    int n;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    chk({28'h0, svm, surge, dtc, loopoff}, 32'h0);
    rreg(AD_A, 32'h0, OK);
    rreg(AD_B, clreg_pkg::CFG_B_RESET, OK);
    wreg(AD_A, 32'hFFFF_FFFF);
    rreg(AD_A, 32'h0000_7FFF, OK);
    for (int i = 0; i < 4; i++) begin
      wreg(AD_A, 32'h1 << BP[i]);
      chk({28'h0, svm, surge, dtc, loopoff}, 32'h8 >> i);
    end
    wreg(AD_B, 32'hA5C3_7E19);
    wr(AD_B, 32'h0000_FF00, 4'h2, r);
    chk({30'h0, r}, {30'h0, OK});
    rreg(AD_B, 32'hA5C3_FF19, OK);
    chk({1'b0, halt, brk, spin, bspd, res, ind}, 32'h25C3_FF19);
    wr(12'h22C, 32'h1234_5678, 4'hF, r);
    chk({30'h0, r}, {30'h0, clreg_pkg::RESP_SLVERR});
    rreg(12'h22C, 32'h0, clreg_pkg::RESP_SLVERR);
    rreg(AD_B, 32'hA5C3_FF19, OK);
    $display("test registers done");
    stop <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      wreg(AD_B, 32'(i) << 28);
      repeat (2) @(posedge clk);
      chk({29'h0, stage}, {29'h0, STG[i]});
    end
    align <= 1'b1;
    wreg(AD_B, 32'h1000_0000);
    for (int i = 0; i < 2; i++) begin
      wreg(AD_A, 32'(i));
      repeat (2) @(posedge clk);
      chk({29'h0, stage}, i == 0 ? 32'h1 : 32'h3);
    end
    stop <= 1'b0;
    repeat (2) @(posedge clk);
    chk({29'h0, stage}, 32'h0);
    $display("test stop stage done");
    for (int i = 0; i < 5; i++) begin
      n = (DV[i] < 2) ? 1 : DV[i];
      wreg(AD_A, 32'(DV[i]) << 8);
      restart(1'b0, 1'b0);
      pulses(4 * n - 1, 3);
    end
    for (int i = 0; i < 8; i++) begin
      wreg(AD_A, 32'(ST[i][4:3]) << 12);
      restart(ST[i][2], ST[i][1]);
      pulses(4, ST[i][0] ? 4 : 0);
    end
    $display("test pulse source done");
    for (int i = 0; i < 8; i++) begin
      coast(3'(i), MV[i]);
    end
    wreg(AD_A, 32'h0);
    restart(1'b0, 1'b0);
    @(posedge clk);
    emf <= 8'hFF;
    driven <= 1'b0;
    pulses(2, 0);
    $display("test pulse activity done");
    conclude();
  end
endmodule
